// *** common/ring_pkg.sv ***
// Behaviour
// - Master mode times backbone from serial bus
// - Master keeps receive elastic store always active
// - Serial clock and frame pulse are inputs
// - Drop backbone channels, insert serial channels
// - Per-channel bypass byte input to output
// - Per-slot serial output tri-state control
// - Equal constant delay for every channel
// - Slave mode times backbone from receive link
// - Locked device drives phase control out
// - All per-channel functions work in slave
// - Received bytes pass elastic store before serial
// - Master bypass delay frame plus phase
// - Slave bypass fixed offset, within twelve microseconds
// - Output frame pulse once per frame
package ring_pkg;
    // Backbone frame geometry
    localparam int          POS_N    = 2430;
    localparam int          POS_W    = 12;
    localparam logic [11:0] POS_LAST = 12'h97d;
    localparam logic [11:0] POS_HALF = 12'h4bf;
    // Serial bus: one stream, 64 slots of 8 bits
    localparam int          SLOT_N   = 64;
    localparam int          SLOT_W   = 6;
    localparam int          BIT_W    = 9;
    localparam logic [2:0]  BIT_LAST = 3'h7;
    // Configuration word layout
    localparam int          CFG_W          = 16;
    localparam int          CFG_BYPASS_BIT = 0;
    localparam int          CFG_INSERT_BIT = 1;
    localparam int          CFG_SLOT_LSB   = 2;
    localparam int          CFG_DROP_OE    = 12;
    // Slave output frame offset behind input frame
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          SLAVE_OFFSET_NS = 1000;
    localparam logic [7:0]  SLAVE_OFFSET_CYC =
        8'((SLAVE_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Output buffer depth
    localparam logic [1:0]  BUF_FULL = 2'h2;
    // Transmit frame generator
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_RUN  = 2'b10
    } tx_state_t;
endpackage

// *** rtl/ring_add_drop_bypass.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_add_drop_bypass (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Timing mode pins and ring selection
    input  wire logic        master_timing_mode,
    input  wire logic        slave_timing_mode,
    input  wire logic        lock_select,
    input  wire logic        phase_ctrl_in,
    output logic             phase_ctrl_out,
    // Serial bus side
    input  wire logic        serial_clk,
    input  wire logic        serial_frame_pulse,
    input  wire logic        serial_rx,
    output logic             serial_tx,
    output logic             serial_tx_oe,
    // Byte input port from framer
    input  wire logic [7:0]  byte_port_in,
    input  wire logic        byte_in_valid,
    input  wire logic        byte_in_frame_pulse,
    // Byte output port to framer
    output logic [7:0]       byte_port_out,
    output logic             byte_out_valid,
    input  wire logic        byte_out_ready,
    output logic             byte_out_frame_pulse,
    // Per-channel configuration port
    input  wire logic        cfg_we,
    input  wire logic        cfg_sel_slot,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [15:0] cfg_data
);

    // Pin synchronisers: stage 1 read only by stage 2
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic       sclk3_q;
    logic       pc3_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q    <= 6'h00;
            s2_q    <= 6'h00;
            sclk3_q <= 1'b0;
            pc3_q   <= 1'b0;
        end else begin
            s1_q    <= {master_timing_mode, slave_timing_mode, phase_ctrl_in,
                        serial_clk, serial_frame_pulse, serial_rx};
            s2_q    <= s1_q;
            sclk3_q <= s2_q[2];
            pc3_q   <= s2_q[3];
        end
    end

    // Slave pin wins; otherwise master timing
    logic slave_m;
    logic sclk_rise;
    logic sfp_s;
    logic srx_s;
    logic pc_rise;
    assign slave_m   = s2_q[4];
    assign sclk_rise = s2_q[2] & ~sclk3_q;
    assign sfp_s     = s2_q[1];
    assign srx_s     = s2_q[0];
    assign pc_rise   = s2_q[3] & ~pc3_q;

    // Per-position and per-slot configuration tables
    logic [2:0]  bypass_tab [ring_pkg::POS_N];
    logic        insert_tab [ring_pkg::POS_N];
    logic [5:0]  slotsel_tab [ring_pkg::POS_N];
    logic [11:0] drop_tab   [ring_pkg::SLOT_N];
    logic        dropoe_tab [ring_pkg::SLOT_N];

    // Table writes; no reset, tables start undefined
    always_ff @(posedge clk) begin
        if (cfg_we && !cfg_sel_slot && cfg_addr <= ring_pkg::POS_LAST) begin
            bypass_tab[cfg_addr]  <= {2'h0, cfg_data[ring_pkg::CFG_BYPASS_BIT]};
            insert_tab[cfg_addr]  <= cfg_data[ring_pkg::CFG_INSERT_BIT];
            slotsel_tab[cfg_addr] <= cfg_data[ring_pkg::CFG_SLOT_LSB +: ring_pkg::SLOT_W];
        end
        if (cfg_we && cfg_sel_slot) begin
            drop_tab[cfg_addr[5:0]]   <= cfg_data[ring_pkg::POS_W-1:0];
            dropoe_tab[cfg_addr[5:0]] <= cfg_data[ring_pkg::CFG_DROP_OE];
        end
    end

    // Receive elastic store: two frame banks
    logic [7:0]  rx_mem [2][ring_pkg::POS_N];
    logic        wbank_q;
    logic [11:0] wpos_q;
    logic        wbank_eff;
    logic [11:0] wpos_eff;
    assign wbank_eff = byte_in_frame_pulse ? ~wbank_q : wbank_q;
    assign wpos_eff  = byte_in_frame_pulse ? 12'h000 : wpos_q;

    // Store writes, always running in either mode
    always_ff @(posedge clk) begin
        if (byte_in_valid && wpos_eff <= ring_pkg::POS_LAST) begin
            rx_mem[wbank_eff][wpos_eff] <= byte_port_in;
        end
    end

    // Write pointer and bank, frame pulse flips bank
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wbank_q <= 1'b0;
            wpos_q  <= 12'h000;
        end else if (byte_in_valid) begin
            wbank_q <= wbank_eff;
            if (wpos_eff <= ring_pkg::POS_LAST) begin
                wpos_q <= wpos_eff + 12'h001;
            end
        end
    end

    // Serial bit counter, reset by the frame pulse
    logic [8:0] bit_q;
    logic [8:0] bit_nx;
    logic [5:0] slot_nx;
    logic       sframe_start;
    assign bit_nx       = sfp_s ? 9'h000 : bit_q + 9'h001;
    assign slot_nx      = bit_nx[8:3];
    assign sframe_start = sclk_rise & sfp_s;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_q <= 9'h1ff;
        end else if (sclk_rise) begin
            bit_q <= bit_nx;
        end
    end

    // Serial side reads the last completed bank
    logic sbank_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sbank_q <= 1'b0;
        end else if (sframe_start) begin
            sbank_q <= ~wbank_q;
        end
    end

    // Insert path: capture serial slot bytes
    logic [7:0] ins_mem [ring_pkg::SLOT_N];
    logic [7:0] rsh_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsh_q <= 8'h00;
        end else if (sclk_rise) begin
            rsh_q <= {rsh_q[6:0], srx_s};
        end
    end

    always_ff @(posedge clk) begin
        if (sclk_rise && bit_nx[2:0] == ring_pkg::BIT_LAST) begin
            ins_mem[slot_nx] <= {rsh_q[6:0], srx_s};
        end
    end

    // Drop path: load slot byte, shift out MSB first
    logic [7:0] tsh_q;
    logic       toe_q;
    logic       sbank_rd; // Slot 0 already reads the newly chosen bank
    assign sbank_rd = sframe_start ? ~wbank_q : sbank_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tsh_q <= 8'h00;
            toe_q <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_nx[2:0] == 3'h0) begin
                // Same frame-aligned bank for every slot
                tsh_q <= rx_mem[sbank_rd][drop_tab[slot_nx]];
                toe_q <= dropoe_tab[slot_nx];
            end else begin
                tsh_q <= {tsh_q[6:0], 1'b0};
            end
        end
    end
    assign serial_tx    = tsh_q[7];
    assign serial_tx_oe = toe_q;

    // Slave offset counter from byte input frame
    logic [7:0] off_q;
    logic       off_run_q;
    logic       off_done;
    assign off_done = off_run_q && off_q == ring_pkg::SLAVE_OFFSET_CYC;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            off_q     <= 8'h00;
            off_run_q <= 1'b0;
        end else if (byte_in_frame_pulse && byte_in_valid) begin
            off_q     <= 8'h01;
            off_run_q <= 1'b1;
        end else if (off_done) begin
            off_run_q <= 1'b0;
        end else if (off_run_q) begin
            off_q <= off_q + 8'h01;
        end
    end

    // Locked device forwards its input frame phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ctrl_out <= 1'b0;
        end else begin
            phase_ctrl_out <= slave_m & lock_select & byte_in_frame_pulse & byte_in_valid;
        end
    end

    // Transmit frame start per timing mode
    logic tx_start;
    logic use_elastic;
    always_comb begin
        if (!slave_m) begin
            tx_start    = sframe_start;
            use_elastic = 1'b1;
        end else if (lock_select) begin
            tx_start    = off_done;
            use_elastic = 1'b0;
        end else begin
            // Second device follows the locked one's phase
            tx_start    = pc_rise;
            use_elastic = 1'b1;
        end
    end

    // Transmit generator state and read bank
    ring_pkg::tx_state_t st_q;
    logic [11:0] tpos_q;
    logic        tbank_q;
    logic        buf_in_ready;
    logic        push;
    assign push = (st_q == ring_pkg::TX_RUN) & buf_in_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= ring_pkg::TX_IDLE;
            tpos_q  <= 12'h000;
            tbank_q <= 1'b0;
        end else if (tx_start) begin
            st_q   <= ring_pkg::TX_RUN;
            tpos_q <= 12'h000;
            if (!use_elastic) begin
                tbank_q <= wbank_q;
            end else if (wpos_q >= ring_pkg::POS_HALF) begin
                // Input half a frame ahead: no slip risk
                tbank_q <= wbank_q;
            end else begin
                // Too close: take previous frame, extra one-frame delay
                tbank_q <= ~wbank_q;
            end
        end else begin
            case (st_q)
                ring_pkg::TX_IDLE: begin
                    st_q <= ring_pkg::TX_IDLE;
                end
                ring_pkg::TX_RUN: begin
                    if (push) begin
                        if (tpos_q == ring_pkg::POS_LAST) begin
                            st_q <= ring_pkg::TX_IDLE;
                        end
                        tpos_q <= tpos_q + 12'h001;
                    end
                end
                default: begin
                    st_q <= ring_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Output byte: bypass, else inserted slot, else idle
    logic [7:0] tx_byte;
    always_comb begin
        if (bypass_tab[tpos_q][0]) begin
            tx_byte = rx_mem[tbank_q][tpos_q];
        end else if (insert_tab[tpos_q]) begin
            // Relies on controller keeping inserts off bypass slots
            tx_byte = ins_mem[slotsel_tab[tpos_q]];
        end else begin
            tx_byte = 8'h00;
        end
    end

    // Two-entry output buffer; byte plus frame flag
    logic [8:0] b0_q;
    logic [8:0] b1_q;
    logic [1:0] cnt_q;
    logic       pop;
    logic [8:0] in_w;
    assign buf_in_ready = cnt_q != ring_pkg::BUF_FULL;
    assign pop          = byte_out_ready & (cnt_q != 2'h0);
    assign in_w         = {tpos_q == 12'h000, tx_byte};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b0_q  <= 9'h000;
            b1_q  <= 9'h000;
            cnt_q <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (cnt_q == 2'h0) begin
                        b0_q <= in_w;
                    end else begin
                        b1_q <= in_w;
                    end
                    cnt_q <= cnt_q + 2'h1;
                end
                2'b01: begin
                    b0_q  <= b1_q;
                    cnt_q <= cnt_q - 2'h1;
                end
                2'b11: begin
                    // Simultaneous: shift and refill
                    if (cnt_q == 2'h1) begin
                        b0_q <= in_w;
                    end else begin
                        b0_q <= b1_q;
                        b1_q <= in_w;
                    end
                end
                default: begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // Head of buffer drives the byte port
    assign byte_port_out        = b0_q[7:0];
    assign byte_out_valid       = cnt_q != 2'h0;
    assign byte_out_frame_pulse = b0_q[8] & byte_out_valid;

endmodule
`default_nettype wire

// *** verif/ring_add_drop_bypass_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // Mode and phase
    input wire logic       slave_timing_mode,
    input wire logic       lock_select,
    input wire logic       phase_ctrl_out,
    // Serial side
    input wire logic       serial_clk,
    input wire logic       serial_frame_pulse,
    input wire logic       serial_tx_oe,
    // Byte ports
    input wire logic       byte_in_valid,
    input wire logic       byte_in_frame_pulse,
    input wire logic [7:0] byte_port_out,
    input wire logic       byte_out_valid,
    input wire logic       byte_out_ready,
    input wire logic       byte_out_frame_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Stalled head word must not move
    a_stall_holds: assert property (
        byte_out_valid && !byte_out_ready |=> byte_out_valid && $stable(byte_port_out))
        else $error("Output word changed under stall");
    // Frame marker only rides a real word
    a_pulse_valid: assert property (byte_out_frame_pulse |-> byte_out_valid)
        else $error("Frame marker without valid word");
    // Phase pulse has an input frame as cause
    a_phase_cause: assert property (
        phase_ctrl_out |-> $past(byte_in_frame_pulse) && $past(byte_in_valid))
        else $error("Phase pulse without input frame");
    // Locked slave: one-cycle phase pulse after the input frame
    a_phase_sent: assert property (
        byte_in_frame_pulse && byte_in_valid && lock_select && slave_timing_mode && $past(slave_timing_mode, 3)
        |=> phase_ctrl_out ##1 !phase_ctrl_out)
        else $error("Phase pulse missing or too long");
    // Master never drives phase control
    a_master_quiet: assert property (
        !slave_timing_mode && !$past(slave_timing_mode, 4) |-> !phase_ctrl_out)
        else $error("Phase pulse in master mode");
    // Locked slave: output frame a fixed offset behind input
    a_slave_start: assert property (
        byte_in_frame_pulse && byte_in_valid && lock_select && slave_timing_mode && $past(slave_timing_mode, 3)
        |-> ##[41:43] byte_out_frame_pulse)
        else $error("Output frame late in slave mode");
    // Master: output frame follows the serial frame pulse
    a_master_start: assert property (
        !slave_timing_mode && !$past(slave_timing_mode, 4) && $rose(serial_clk) && serial_frame_pulse
        |-> ##[3:9] byte_out_frame_pulse)
        else $error("Output frame not started by serial frame");
    // Drive enable moves only on a serial bit event
    a_oe_on_slot: assert property ($changed(serial_tx_oe) |-> $past(serial_clk, 3))
        else $error("Serial enable changed between bits");
endmodule
bind ring_add_drop_bypass ring_asserts u_asserts (
    .clk(clk), .arst_n(arst_n), .slave_timing_mode(slave_timing_mode), .lock_select(lock_select),
    .phase_ctrl_out(phase_ctrl_out), .serial_clk(serial_clk), .serial_frame_pulse(serial_frame_pulse),
    .serial_tx_oe(serial_tx_oe), .byte_in_valid(byte_in_valid), .byte_in_frame_pulse(byte_in_frame_pulse),
    .byte_port_out(byte_port_out), .byte_out_valid(byte_out_valid), .byte_out_ready(byte_out_ready),
    .byte_out_frame_pulse(byte_out_frame_pulse)
);
`default_nettype wire

// *** verif/ring_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_far_side (
    // Receiver clock
    input wire logic  clk,
    // Serial bus timing and data
    output logic       serial_clk,
    output logic       serial_frame_pulse,
    output logic       serial_rx,
    input wire logic   serial_tx,
    input wire logic   serial_tx_oe,
    // Byte receiver flow control
    output logic       byte_out_ready,
    // Last captured slot
    output logic [5:0] got_slot,
    output logic [7:0] got_byte,
    output logic       got_oe,
    output logic       got_stb
);
    localparam logic [7:0] RX_PAT = 8'ha5; // Sent in every slot
    logic [8:0] bit_q;                     // Bit whose rise just passed
    logic [7:0] sh_q;                      // Serial output shifter
    logic [7:0] rdy_q;                     // Stall pattern counter
    initial begin
        bit_q = 9'h1ff;
        sh_q = 8'h00;
        rdy_q = 8'h00;
        serial_clk = 1'b0;
        serial_frame_pulse = 1'b1;
        serial_rx = RX_PAT[7];
        byte_out_ready = 1'b0;
        got_stb = 1'b0;
    end
    // Bus clock runs free, 512 bits per 125 us frame
    always #122.07 serial_clk = ~serial_clk;
    // Take the bit that just ended, flag a whole slot
    always @(posedge serial_clk) begin
        // Released line floats high through its pull-up
        sh_q = {sh_q[6:0], serial_tx_oe ? serial_tx : 1'b1};
        if (bit_q[2:0] == 3'h7) begin
            got_slot = bit_q[8:3];
            got_byte = sh_q;
            got_oe = serial_tx_oe;
        end
        got_stb <= (bit_q[2:0] == 3'h7);
        bit_q = bit_q + 9'h001;
    end
    // Change well away from where the device samples
    always @(negedge serial_clk) begin
        #60;
        serial_frame_pulse = (bit_q == 9'h1ff);
        serial_rx = RX_PAT[3'h6 - bit_q[2:0]];
    end
    // Two stall cycles in eight fill the buffer to refusal
    always @(negedge clk) begin
        rdy_q = rdy_q + 8'h01;
        byte_out_ready = (rdy_q[2:1] != 2'h0);
    end
endmodule
`default_nettype wire

// *** verif/tb_ring_add_drop_bypass.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ring_add_drop_bypass;
    typedef struct packed {
        logic [11:0] pos;
        logic [15:0] word;
        logic [7:0]  exp;
    } row_t;
    // Position, config word, byte that must come out
    localparam row_t ROWS [7] = '{
        '{12'h000, 16'h0001, 8'h5a}, '{12'h001, 16'h0000, 8'h00}, '{12'h002, 16'h000e, 8'ha5},
        '{12'h003, 16'h0001, 8'h59}, '{12'h4bf, 16'h0001, 8'he5}, '{12'h97d, 16'h0001, 8'h27},
        '{12'h97c, 16'h00fe, 8'ha5}};
    // Mode rows: slave, lock
    localparam logic [1:0] MODES [3] = '{2'h0, 2'h3, 2'h2};
    logic        clk, arst_n, slave_timing_mode, lock_select, phase_ctrl_in;
    logic        byte_in_valid, byte_in_frame_pulse, cfg_we, cfg_sel_slot, armed, uflag;
    logic [7:0]  byte_port_in;
    logic [11:0] cfg_addr;
    logic [15:0] cfg_data;
    wire         phase_ctrl_out, serial_clk, serial_frame_pulse, serial_rx, serial_tx, serial_tx_oe;
    wire  [7:0]  byte_port_out, got_byte;
    wire  [5:0]  got_slot;
    wire         byte_out_valid, byte_out_ready, byte_out_frame_pulse, got_oe, got_stb;
    wire         master_timing_mode = ~slave_timing_mode;
    logic [7:0]  exp_b [ring_pkg::POS_N]; // Expected byte per position
    int          opos, n_errors, check_count;
    ring_add_drop_bypass dut (
        .clk(clk), .arst_n(arst_n), .master_timing_mode(master_timing_mode),
        .slave_timing_mode(slave_timing_mode), .lock_select(lock_select), .phase_ctrl_in(phase_ctrl_in),
        .phase_ctrl_out(phase_ctrl_out), .serial_clk(serial_clk), .serial_frame_pulse(serial_frame_pulse),
        .serial_rx(serial_rx), .serial_tx(serial_tx), .serial_tx_oe(serial_tx_oe),
        .byte_port_in(byte_port_in), .byte_in_valid(byte_in_valid), .byte_in_frame_pulse(byte_in_frame_pulse),
        .byte_port_out(byte_port_out), .byte_out_valid(byte_out_valid), .byte_out_ready(byte_out_ready),
        .byte_out_frame_pulse(byte_out_frame_pulse), .cfg_we(cfg_we), .cfg_sel_slot(cfg_sel_slot),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data));
    ring_far_side u_far (
        .clk(clk), .serial_clk(serial_clk), .serial_frame_pulse(serial_frame_pulse), .serial_rx(serial_rx),
        .serial_tx(serial_tx), .serial_tx_oe(serial_tx_oe), .byte_out_ready(byte_out_ready),
        .got_slot(got_slot), .got_byte(got_byte), .got_oe(got_oe), .got_stb(got_stb));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("ERROR t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One config write, strobe held across one rising edge
    task automatic cfg(input logic sel, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        cfg_we = 1'b1;
        cfg_sel_slot = sel;
        cfg_addr = a;
        cfg_data = d;
        @(negedge clk);
        cfg_we = 1'b0;
    endtask
    // One backbone frame, a byte every other cycle, same data each frame
    task automatic frame();
        for (int p = 0; p < ring_pkg::POS_N; p++) begin
            @(negedge clk);
            byte_in_valid = 1'b1;
            byte_in_frame_pulse = (p == 0);
            byte_port_in = 8'(p) ^ 8'h5a;
            phase_ctrl_in = uflag && (p == 20);
            @(negedge clk);
            byte_in_valid = 1'b0;
        end
        repeat (140) @(negedge clk);
    endtask
    // Armed frames: every popped byte against the table; pops counted per frame
    always @(posedge clk) begin
        if (!arst_n) begin
            opos = 0;
        end else if (byte_out_valid === 1'b1 && byte_out_ready) begin
            if (byte_out_frame_pulse === 1'b1) begin
                if (armed) chk(12'(opos), 12'(ring_pkg::POS_N));
                opos = 0;
            end
            if (armed) chk({4'h0, byte_port_out}, {4'h0, exp_b[opos]});
            opos++;
        end
    end
    // Dropped bytes and drive enable per slot
    always @(posedge got_stb) begin
        if (armed) begin
            chk({11'h0, got_oe}, {11'h0, ~got_slot[0]});
            chk({4'h0, got_byte}, {4'h0, got_slot[0] ? 8'hff : 8'(got_slot * 7) ^ 8'h5a});
        end
    end
    // Cut a hang short, run needs about 60000 cycles
    initial begin
        #2000000;
        n_errors++;
        end_sim();
    end
    initial begin
        // Quiet inputs at time zero, reset held 12 cycles
        // Locked slave while tables fill: no output frame reads the unwritten store
        {clk, arst_n, slave_timing_mode, lock_select, phase_ctrl_in, uflag, armed} = 7'h18;
        {byte_in_valid, byte_in_frame_pulse, cfg_we, cfg_sel_slot, byte_port_in} = 12'h000;
        {cfg_addr, cfg_data} = 28'h0000000;
        {n_errors, check_count} = 64'h0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        // Tables are not reset, so every entry is written
        for (int p = 0; p < ring_pkg::POS_N; p++) begin
            exp_b[p] = 8'h00;
            cfg(1'b0, 12'(p), 16'h0000);
        end
        for (int i = 0; i < 7; i++) begin
            cfg(1'b0, ROWS[i].pos, ROWS[i].word);
            exp_b[ROWS[i].pos] = ROWS[i].exp;
        end
        for (int s = 0; s < ring_pkg::SLOT_N; s++) cfg(1'b1, 12'(s), {3'h0, ~s[0], 12'(s * 7)});
        cfg(1'b0, 12'h97e, 16'h0001); // Past the last position: ignored
        // Each mode: reset, fill both banks, then check a frame
        for (int m = 0; m < 3; m++) begin
            arst_n = 1'b0;
            {slave_timing_mode, lock_select} = MODES[m];
            uflag = (MODES[m] == 2'h2);
            repeat (12) @(negedge clk);
            arst_n = 1'b1;
            // Mode pins need their synchroniser delay before the first frame
            repeat (4) @(negedge clk);
            for (int f = 0; f < 3; f++) begin
                armed = (f == 2);
                frame();
            end
            armed = 1'b0;
        end
        // Ring failure: controller loops every channel straight through
        for (int p = 0; p < ring_pkg::POS_N; p++) begin
            exp_b[p] = 8'(p) ^ 8'h5a;
            cfg(1'b0, 12'(p), 16'h0001);
        end
        armed = 1'b1;
        frame();
        armed = 1'b0;
        // Outputs clear while reset is held
        arst_n = 1'b0;
        @(negedge clk);
        chk({byte_out_valid, phase_ctrl_out, serial_tx_oe, serial_tx, byte_port_out}, 12'h000);
        end_sim();
    end
endmodule
`default_nettype wire
